// ### cls_pkg.sv
// Shared constants, types and decoding for the current limit and
// load step emulation command registers.
// Assumes a 200 MHz system clock and a two-page (two master) device.
package cls_pkg;

  // ==========================================================
  // Command codes
  // ==========================================================
  localparam logic [7:0] CLS_CODE_GAIN  = 8'h38; // Current sense gain
  localparam logic [7:0] CLS_CODE_FAULT = 8'h46; // Phase OC fault limit
  localparam logic [7:0] CLS_CODE_WARN  = 8'h4a; // Phase OC warn limit
  localparam logic [7:0] CLS_CODE_EMU   = 8'hf7; // Emulation control

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [15:0] CLS_GAIN_RESET  = 16'hca80; // 5 milliohm
  localparam logic [15:0] CLS_FAULT_RESET = 16'hdbb8; // 29.75 A
  localparam logic [15:0] CLS_WARN_RESET  = 16'hda80; // 20.0 A
  localparam logic [3:0]  CLS_EMU_RESET   = 4'h0;     // Emulation off

  // ==========================================================
  // Emulation control field positions
  // ==========================================================
  localparam int CLS_EMU_SCOPE_BIT = 3; // Scope trigger arm
  localparam int CLS_EMU_MODE_BIT  = 2; // 1 = pulsed
  localparam int CLS_EMU_MAG_HI    = 1; // Magnitude msb
  localparam int CLS_EMU_MAG_LO    = 0; // Magnitude lsb
  localparam int CLS_EMU_WIDTH     = 4; // Implemented bits

  // Magnitude codes, per phase at 5 milliohm gain
  localparam logic [1:0] CLS_MAG_OFF = 2'h0; // Off
  localparam logic [1:0] CLS_MAG_10A = 2'h1; // 10 A
  localparam logic [1:0] CLS_MAG_20A = 2'h2; // 20 A
  localparam logic [1:0] CLS_MAG_30A = 2'h3; // 30 A

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int CLS_CLK_PERIOD_PS = 5000;      // 200 MHz
  localparam int CLS_PULSE_NS      = 100000;    // 100 us pulse
  localparam int CLS_PULSE_CYCLES  = (CLS_PULSE_NS * 1000) / CLS_CLK_PERIOD_PS;
  localparam int CLS_PAGES         = 2;         // Master channels

  // ==========================================================
  // Types
  // ==========================================================
  // One command from the protocol engine
  typedef struct packed {
    logic        valid; // Command strobe
    logic        write; // 1 write, 0 read
    logic        page;  // Addressed master
    logic [7:0]  code;  // Command code
    logic [15:0] wdata; // Write data, byte commands in low bits
  } cls_cmd_type;

  // Emulation control field layout
  typedef struct packed {
    logic       scope_arm; // Trigger on power good fall
    logic       pulsed;    // Pulsed mode
    logic [1:0] magnitude; // Step size
  } cls_emu_ctrl_type;

  typedef enum logic
  {
    CLS_EMU_IDLE  = 1'b0,
    CLS_EMU_PULSE = 1'b1
  } cls_emu_state_type;

  // ==========================================================
  // Linear 5s/11s to signed fixed point, 16 fractional bits
  // ==========================================================
  function automatic logic signed [47:0] cls_linear_value(input logic [15:0] v);
    logic signed [47:0] m;
    logic [5:0]         amount;
    m      = {{37{v[10]}}, v[10:0]} <<< 16;
    amount = 6'h20 - {1'b0, v[15:11]};
    if (v[15])
      cls_linear_value = m >>> amount;
    else
      cls_linear_value = m <<< v[14:11];
  endfunction

endpackage

// ### cls_load_emulator.sv
// Load step emulator for one master channel: static or pulsed level
// plus the power good scope trigger.
// Assumes power_good is synchronous to clk and the write strobe is one
// cycle long.
module cls_load_emulator
  import cls_pkg::*;
#(
  parameter int PULSE_CYCLES = CLS_PULSE_CYCLES
)
(
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             clk_en,
  input  wire cls_emu_ctrl_type ctrl,
  input  wire logic             write_strobe,
  input  wire cls_emu_ctrl_type write_value,
  input  wire logic             power_good,
  output logic [1:0]            emulated_load_step,
  output logic                  scope_trigger
);

  // ==========================================================
  // State
  // ==========================================================
  cls_emu_state_type state;        // Pulse sequencer
  cls_emu_state_type next_state;
  logic [31:0]       count;        // Cycles left in pulse
  logic [31:0]       next_count;
  logic [1:0]        level;        // Step being applied
  logic [1:0]        next_level;
  logic              pg_prev;      // Power good one cycle ago
  logic              next_pg_prev;
  logic              trig;         // Scope trigger pulse
  logic              next_trig;

  // ==========================================================
  // Next values
  // ==========================================================
  always_comb
  begin
    next_state   = state;
    next_count   = count;
    next_level   = level;
    next_pg_prev = power_good;
    // Scope trigger on a power good falling edge while armed
    next_trig    = ctrl.scope_arm & pg_prev & ~power_good;
    case (state)
      CLS_EMU_IDLE:
      begin
        if (!ctrl.pulsed)
          // Static level follows the stored magnitude
          next_level = ctrl.magnitude;
        else
          next_level = CLS_MAG_OFF;
        // A nonzero pulsed write starts one pulse
        if (write_strobe && write_value.pulsed && write_value.magnitude != CLS_MAG_OFF)
        begin
          next_state = CLS_EMU_PULSE;
          next_level = write_value.magnitude;
          next_count = 32'(PULSE_CYCLES - 1);
        end
      end
      CLS_EMU_PULSE:
      begin
        // Further writes during the pulse are not restarted
        if (count == 32'h0)
        begin
          next_state = CLS_EMU_IDLE;
          next_level = CLS_MAG_OFF;
        end
        else
          next_count = count - 32'h1;
      end
      default:
      begin
        next_state = CLS_EMU_IDLE;
        next_level = CLS_MAG_OFF;
      end
    endcase
  end

  // ==========================================================
  // Registers, frozen while clk_en is low
  // ==========================================================
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state   <= CLS_EMU_IDLE;
      count   <= 32'h0;
      level   <= CLS_MAG_OFF;
      pg_prev <= 1'b0;
      trig    <= 1'b0;
    end
    else if (clk_en)
    begin
      state   <= next_state;
      count   <= next_count;
      level   <= next_level;
      pg_prev <= next_pg_prev;
      trig    <= next_trig;
    end
  end

  assign emulated_load_step = level;
  assign scope_trigger      = trig;

endmodule

// ### cls_current_limit_regs.sv
// Current calibration, phase overcurrent limits and load step
// emulation command registers for both master channels.
// Assumes a protocol engine delivers decoded commands on cmd and that
// all inputs are synchronous to clk.
//
// Operation
// - Gain write while any channel on faults
// - Gain register, two bytes, default 5 milliohm
// - Emulation control byte, reset zero, per channel
// - Armed bit 3 triggers on power good fall
// - Static mode level follows magnitude bits
// - Pulsed mode nonzero write gives 100 us pulse
// - Magnitude codes 30, 20, 10 A, off
// - Fault limit register, default 29.75 A
// - Warn limit compared with average phase current
// - Warning sets status bits and unmasked alert
// - Fault detection suppressed while output ramps
module cls_current_limit_regs
  import cls_pkg::*;
#(
  parameter int PULSE_CYCLES = CLS_PULSE_CYCLES,
  parameter int PAGES        = CLS_PAGES
)
(
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              clk_en,
  input  wire cls_cmd_type       cmd,
  output logic [15:0]            read_data,
  output logic                   read_valid,
  output logic                   comm_fault,
  input  wire logic [PAGES-1:0]  channel_enabled,
  input  wire logic [PAGES-1:0]  output_ramping,
  input  wire logic [PAGES-1:0]  power_good,
  input  wire logic [PAGES*16-1:0] phase_current_peak,
  input  wire logic [PAGES*16-1:0] phase_current_avg,
  input  wire logic [PAGES-1:0]  alert_mask,
  input  wire logic              clear_status,
  output logic [PAGES-1:0]       overcurrent_fault,
  output logic [PAGES-1:0]       status_word_iout,
  output logic [PAGES-1:0]       status_iout_oc_warn,
  output logic                   alert_n,
  output logic [PAGES*2-1:0]     emulated_load_step,
  output logic [PAGES-1:0]       scope_trigger
);

  // ==========================================================
  // Register storage, one entry per page
  // ==========================================================
  logic [15:0]      gain [PAGES];        // Current sense gain
  logic [15:0]      next_gain [PAGES];
  logic [15:0]      fault_lim [PAGES];   // Phase OC fault limit
  logic [15:0]      next_fault_lim [PAGES];
  logic [15:0]      warn_lim [PAGES];    // Phase OC warn limit
  logic [15:0]      next_warn_lim [PAGES];
  cls_emu_ctrl_type emu_ctrl [PAGES];    // Emulation control
  cls_emu_ctrl_type next_emu_ctrl [PAGES];

  // ==========================================================
  // Read side and fault strobe
  // ==========================================================
  logic [15:0] rdata;          // Registered read word
  logic [15:0] next_rdata;
  logic        rvalid;         // Read answer strobe
  logic        next_rvalid;
  logic        cfault;         // Communication fault pulse
  logic        next_cfault;

  // ==========================================================
  // Limit monitors
  // ==========================================================
  logic [PAGES-1:0] oc_fault;      // Live fault detect
  logic [PAGES-1:0] next_oc_fault;
  logic [PAGES-1:0] warn_word;     // Sticky summary bit
  logic [PAGES-1:0] next_warn_word;
  logic [PAGES-1:0] warn_iout;     // Sticky OC warning bit
  logic [PAGES-1:0] next_warn_iout;
  logic [PAGES-1:0] alert_q;       // Alert asserted
  logic [PAGES-1:0] next_alert_q;

  // Emulator write strobes, one per page
  logic [PAGES-1:0] emu_write;

  // Any master still on blocks gain changes
  logic any_on;
  assign any_on = |channel_enabled;

  // Decode of a write to a given code and page
  function automatic logic is_write(input cls_cmd_type c, input logic [7:0] code,
                                    input int page);
    is_write = c.valid & c.write & (c.code == code) & (int'(c.page) == page);
  endfunction

  // ==========================================================
  // Register writes
  // ==========================================================
  always_comb
  begin
    next_cfault = 1'b0;
    for (int p = 0; p < PAGES; p++)
    begin
      next_gain[p]      = gain[p];
      next_fault_lim[p] = fault_lim[p];
      next_warn_lim[p]  = warn_lim[p];
      next_emu_ctrl[p]  = emu_ctrl[p];
      emu_write[p]      = 1'b0;
      if (is_write(cmd, CLS_CODE_GAIN, p))
      begin
        // Changing gain under a running output would upset current sense
        if (any_on)
          next_cfault = 1'b1;
        else
          next_gain[p] = cmd.wdata;
      end
      if (is_write(cmd, CLS_CODE_FAULT, p))
        next_fault_lim[p] = cmd.wdata;
      if (is_write(cmd, CLS_CODE_WARN, p))
        next_warn_lim[p] = cmd.wdata;
      if (is_write(cmd, CLS_CODE_EMU, p))
      begin
        // Upper bits are dropped, only the implemented field is kept
        next_emu_ctrl[p] = cmd.wdata[CLS_EMU_WIDTH-1:0];
        emu_write[p]     = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int p = 0; p < PAGES; p++)
      begin
        gain[p]      <= CLS_GAIN_RESET;
        fault_lim[p] <= CLS_FAULT_RESET;
        warn_lim[p]  <= CLS_WARN_RESET;
        emu_ctrl[p]  <= CLS_EMU_RESET;
      end
      cfault <= 1'b0;
    end
    else if (clk_en)
    begin
      for (int p = 0; p < PAGES; p++)
      begin
        gain[p]      <= next_gain[p];
        fault_lim[p] <= next_fault_lim[p];
        warn_lim[p]  <= next_warn_lim[p];
        emu_ctrl[p]  <= next_emu_ctrl[p];
      end
      cfault <= next_cfault;
    end
  end

  // ==========================================================
  // Register reads
  // ==========================================================
  always_comb
  begin
    next_rvalid = cmd.valid & ~cmd.write;
    next_rdata  = rdata;
    if (cmd.valid && !cmd.write)
    begin
      case (cmd.code)
        CLS_CODE_GAIN:  next_rdata = gain[cmd.page];
        CLS_CODE_FAULT: next_rdata = fault_lim[cmd.page];
        CLS_CODE_WARN:  next_rdata = warn_lim[cmd.page];
        // Reserved bits come back as zero
        CLS_CODE_EMU:   next_rdata = {12'h000, emu_ctrl[cmd.page]};
        // Codes outside this block answer zero
        default:        next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rdata  <= 16'h0000;
      rvalid <= 1'b0;
    end
    else if (clk_en)
    begin
      rdata  <= next_rdata;
      rvalid <= next_rvalid;
    end
  end

  // ==========================================================
  // Overcurrent fault and warning monitors
  // ==========================================================
  always_comb
  begin
    for (int p = 0; p < PAGES; p++)
    begin
      // Ramps draw inrush current, so no fault is judged then
      next_oc_fault[p] = ~output_ramping[p] &
        (cls_linear_value(phase_current_peak[p*16 +: 16]) >
         cls_linear_value(fault_lim[p]));
      next_warn_word[p] = warn_word[p] & ~clear_status;
      next_warn_iout[p] = warn_iout[p] & ~clear_status;
      // A new warning wins over a clear in the same cycle
      if (!output_ramping[p] &&
          cls_linear_value(phase_current_avg[p*16 +: 16]) >
          cls_linear_value(warn_lim[p]))
      begin
        next_warn_word[p] = 1'b1;
        next_warn_iout[p] = 1'b1;
      end
      next_alert_q[p] = next_warn_iout[p] & ~alert_mask[p];
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      oc_fault  <= '0;
      warn_word <= '0;
      warn_iout <= '0;
      alert_q   <= '0;
    end
    else if (clk_en)
    begin
      oc_fault  <= next_oc_fault;
      warn_word <= next_warn_word;
      warn_iout <= next_warn_iout;
      alert_q   <= next_alert_q;
    end
  end

  // ==========================================================
  // Load step emulators, one per master channel
  // ==========================================================
  generate
    for (genvar g = 0; g < PAGES; g++)
    begin : gen_emu
      cls_load_emulator
      #(
        .PULSE_CYCLES (PULSE_CYCLES)
      )
      u_emu
      (
        .clk                (clk),
        .reset_n            (reset_n),
        .clk_en             (clk_en),
        .ctrl               (emu_ctrl[g]),
        .write_strobe       (emu_write[g]),
        .write_value        (cmd.wdata[CLS_EMU_WIDTH-1:0]),
        .power_good         (power_good[g]),
        .emulated_load_step (emulated_load_step[g*2 +: 2]),
        .scope_trigger      (scope_trigger[g])
      );
    end
  endgenerate

  // ==========================================================
  // Outputs
  // ==========================================================
  assign read_data           = rdata;
  assign read_valid          = rvalid;
  assign comm_fault          = cfault;
  assign overcurrent_fault   = oc_fault;
  assign status_word_iout    = warn_word;
  assign status_iout_oc_warn = warn_iout;
  assign alert_n             = ~(|alert_q);

endmodule

// ### cls_regs_monitor.sv
// Port-level checker for the command register block.
// Assumes clk_en high while pulse timing is judged and page 0 as reference.
module cls_regs_monitor
  import cls_pkg::*;
#(
  parameter int PULSE_CYCLES = CLS_PULSE_CYCLES,
  parameter int PAGES        = CLS_PAGES
)
(
  input wire logic               clk,
  input wire logic               reset_n,
  input wire logic               clk_en,
  input wire cls_cmd_type        cmd,
  input wire logic [15:0]        read_data,
  input wire logic               read_valid,
  input wire logic               comm_fault,
  input wire logic [PAGES-1:0]   channel_enabled,
  input wire logic [PAGES-1:0]   output_ramping,
  input wire logic [PAGES-1:0]   power_good,
  input wire logic [PAGES-1:0]   overcurrent_fault,
  input wire logic [PAGES-1:0]   status_word_iout,
  input wire logic [PAGES-1:0]   status_iout_oc_warn,
  input wire logic [PAGES*2-1:0] emulated_load_step,
  input wire logic [PAGES-1:0]   scope_trigger
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Pulse tracking, page 0
  // ==========================================================
  logic [1:0] step0;     // Page 0 level
  logic       pulse_go;  // Pulse start accepted
  int         cnt0;      // Pulse cycles left
  int         next_cnt0; // Next count
  assign step0    = emulated_load_step[1:0];
  // Only an idle channel starts a pulse; writes mid-pulse keep timing
  assign pulse_go = clk_en && cmd.valid && cmd.write && !cmd.page
                    && cmd.code == CLS_CODE_EMU && cmd.wdata[2]
                    && cmd.wdata[1:0] != CLS_MAG_OFF && step0 == CLS_MAG_OFF;
  // Count down the expected pulse width
  always_comb
  begin
    next_cnt0 = cnt0;
    if (pulse_go)
      next_cnt0 = PULSE_CYCLES;
    else if (cnt0 != 0)
      next_cnt0 = cnt0 - 1;
  end
  // Register the count
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      cnt0 <= 0;
    else
      cnt0 <= next_cnt0;
  end
  // ==========================================================
  // Properties
  // ==========================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_pulse_go;
    pulse_go;
  endsequence
  sequence s_gain_refused;
    clk_en && cmd.valid && cmd.write && cmd.code == CLS_CODE_GAIN && |channel_enabled;
  endsequence
  property p_gain_fault;
    s_gain_refused |=> comm_fault;
  endproperty
  a_gain_fault: assert property (p_gain_fault) else $error("gain write not refused");
  property p_read_answer;
    clk_en && cmd.valid && !cmd.write |=> read_valid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered");
  property p_emu_high;
    read_valid && $past(cmd.valid) && $past(cmd.code) == CLS_CODE_EMU |-> read_data[15:4] == 12'h0;
  endproperty
  a_emu_high: assert property (p_emu_high) else $error("reserved bits not zero");
  property p_static;
    clk_en && cmd.valid && cmd.write && !cmd.page && cmd.code == CLS_CODE_EMU && !cmd.wdata[2]
      |-> ##2 step0 == $past(cmd.wdata[1:0], 2);
  endproperty
  a_static: assert property (p_static) else $error("static level wrong");
  property p_pulse_start;
    s_pulse_go |=> step0 == $past(cmd.wdata[1:0]);
  endproperty
  a_pulse_start: assert property (p_pulse_start) else $error("pulse level wrong");
  property p_pulse_hold;
    cnt0 != 0 |-> step0 != CLS_MAG_OFF;
  endproperty
  a_pulse_hold: assert property (p_pulse_hold) else $error("pulse ended early");
  property p_pulse_end;
    cnt0 == 1 |=> step0 == CLS_MAG_OFF;
  endproperty
  a_pulse_end: assert property (p_pulse_end) else $error("pulse too long");
  property p_scope;
    scope_trigger[0] |-> !$past(power_good[0]) ##1 !scope_trigger[0];
  endproperty
  a_scope: assert property (p_scope) else $error("scope trigger wrong");
  property p_ramp;
    output_ramping[0] |=> !overcurrent_fault[0];
  endproperty
  a_ramp: assert property (p_ramp) else $error("fault while ramping");
  property p_warn_pair;
    status_iout_oc_warn[0] |-> status_word_iout[0];
  endproperty
  a_warn_pair: assert property (p_warn_pair) else $error("warn bits disagree");
endmodule

bind cls_current_limit_regs cls_regs_monitor #(.PULSE_CYCLES(PULSE_CYCLES), .PAGES(PAGES)) u_mon (
  .clk(clk), .reset_n(reset_n), .clk_en(clk_en), .cmd(cmd), .read_data(read_data),
  .read_valid(read_valid), .comm_fault(comm_fault), .channel_enabled(channel_enabled),
  .output_ramping(output_ramping), .power_good(power_good),
  .overcurrent_fault(overcurrent_fault), .status_word_iout(status_word_iout),
  .status_iout_oc_warn(status_iout_oc_warn), .emulated_load_step(emulated_load_step),
  .scope_trigger(scope_trigger));

// ### cls_host_model.sv
// Management bus host model issuing decoded commands.
// Assumes commands are launched on the falling clock edge.
module cls_host_model
  import cls_pkg::*;
(
  input wire logic    clk,
  output cls_cmd_type cmd
);
  timeunit 1ns;
  timeprecision 1ps;
  initial cmd = '0;
  // One command, strobe for one cycle; idle fields scrambled, not held
  task automatic send(input logic w, input logic p, input logic [7:0] c, input logic [15:0] d);
    @(negedge clk);
    cmd <= '{valid: 1'b1, write: w, page: p, code: c, wdata: d};
    @(negedge clk);
    cmd <= '{valid: 1'b0, write: ~w, page: ~p, code: ~c, wdata: ~d};
  endtask
endmodule

// ### testbench.sv
// Self-checking bench for the command register block.
// Assumes clk_en high except for one frozen write; a short pulse keeps the run brief.
module testbench;
  import cls_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PULSE = 20; // Shortened pulse
  logic clk = 0, reset_n = 0, clear_status = 0, clk_en = 1;
  logic [1:0] channel_enabled = 0, output_ramping = 0, power_good = 2'h3, alert_mask = 2'h2;
  logic [31:0] phase_current_peak = 0, phase_current_avg = 0;
  logic [15:0] read_data;
  logic read_valid, comm_fault, alert_n;
  logic [1:0] overcurrent_fault, status_word_iout, status_iout_oc_warn, scope_trigger;
  logic [3:0] emulated_load_step, hits0, hits1;
  logic [9:0] mant;
  logic [15:0] mdl[int]; // Register model
  logic [7:0] codes[5] = '{CLS_CODE_GAIN, CLS_CODE_FAULT, CLS_CODE_WARN, CLS_CODE_EMU, 8'h55};
  cls_cmd_type cmd;
  int miscompares = 0, checked = 0, cycles = 0;
  cls_host_model host (.clk(clk), .cmd(cmd));
  cls_current_limit_regs #(.PULSE_CYCLES(PULSE), .PAGES(2)) uut (
    .clk(clk), .reset_n(reset_n), .clk_en(clk_en), .cmd(cmd), .read_data(read_data),
    .read_valid(read_valid), .comm_fault(comm_fault), .channel_enabled(channel_enabled),
    .output_ramping(output_ramping), .power_good(power_good),
    .phase_current_peak(phase_current_peak), .phase_current_avg(phase_current_avg),
    .alert_mask(alert_mask), .clear_status(clear_status),
    .overcurrent_fault(overcurrent_fault), .status_word_iout(status_word_iout),
    .status_iout_oc_warn(status_iout_oc_warn), .alert_n(alert_n),
    .emulated_load_step(emulated_load_step), .scope_trigger(scope_trigger));
  always #2.5 clk = ~clk;
  // ==========================================================
  // Compare and closing tasks
  // ==========================================================
  task automatic chk_word(input logic [15:0] a, input logic [15:0] e, input string m);
    checked++;
    if (a !== e)
    begin
      miscompares++;
      $display("[FAIL] %0t %s got %h want %h", $time, m, a, e);
    end
  endtask
  task automatic chk_bits(input logic [3:0] a, input logic [3:0] e, input string m);
    chk_word({12'h0, a}, {12'h0, e}, m);
  endtask
  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Hang guard, far above the expected few hundred cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      end_sim();
    end
  end
  // Write through the host; model keeps refused gain writes out
  task automatic wr(input logic p, input logic [7:0] c, input logic [15:0] d);
    logic bad;
    bad = c == CLS_CODE_GAIN && |channel_enabled;
    host.send(1'b1, p, c, d);
    chk_bits({3'h0, comm_fault}, {3'h0, bad}, "comm fault");
    if (!bad && mdl.exists(p * 256 + c))
      mdl[p * 256 + c] = c == CLS_CODE_EMU ? d & 16'h000f : d;
  endtask
  // Read every code on both pages, unknown code included
  task automatic rd_all;
    for (int p = 0; p < 2; p++)
      foreach (codes[i])
      begin
        host.send(1'b0, 1'(p), codes[i], 16'h0);
        chk_bits({3'h0, read_valid}, 4'h1, "read valid");
        chk_word(read_data, mdl.exists(p * 256 + codes[i]) ? mdl[p * 256 + codes[i]] : 16'h0,
                 "read data");
      end
  endtask
  // ==========================================================
  // Main sequence
  // ==========================================================
  initial
  begin
    void'($urandom(83));
    for (int p = 0; p < 2; p++)
    begin
      mdl[p * 256 + CLS_CODE_GAIN]  = CLS_GAIN_RESET;
      mdl[p * 256 + CLS_CODE_FAULT] = CLS_FAULT_RESET;
      mdl[p * 256 + CLS_CODE_WARN]  = CLS_WARN_RESET;
      mdl[p * 256 + CLS_CODE_EMU]   = 16'h0000;
    end
    repeat (8) @(posedge clk);
    @(negedge clk) reset_n = 1'b1;
    rd_all();
    // Random limits on page 1, gain writes while a channel runs
    repeat (4)
    begin
      wr(1'b1, CLS_CODE_FAULT, 16'($urandom));
      wr(1'b1, CLS_CODE_WARN, 16'($urandom));
      channel_enabled = 2'($urandom_range(1, 3));
      wr(1'b0, CLS_CODE_GAIN, 16'($urandom));
    end
    channel_enabled = 2'h0;
    wr(1'b1, CLS_CODE_GAIN, 16'hc280);
    wr(1'b0, CLS_CODE_EMU, 16'hfff0);
    rd_all();
    // Static levels, checked at once and after a long hold
    for (int m = 3; m >= 0; m--)
    begin
      wr(1'b0, CLS_CODE_EMU, 16'(m));
      @(negedge clk);
      chk_bits(emulated_load_step, {2'h0, 2'(m)}, "static");
      repeat (PULSE + 5) @(negedge clk);
      chk_bits(emulated_load_step, {2'h0, 2'(m)}, "static hold");
    end
    // Pulsed writes of every magnitude, zero gives nothing
    for (int m = 0; m < 4; m++)
    begin
      wr(1'b0, CLS_CODE_EMU, 16'(4 + m));
      for (int i = 0; i <= PULSE; i++)
      begin
        chk_bits(emulated_load_step, {2'h0, i < PULSE ? 2'(m) : 2'h0}, "pulse");
        @(negedge clk);
      end
    end
    // Write under a frozen clock enable must leave the level alone
    clk_en = 1'b0;
    host.send(1'b1, 1'b0, CLS_CODE_EMU, 16'h0001);
    repeat (2) @(negedge clk);
    chk_bits(emulated_load_step, 4'h0, "frozen");
    clk_en = 1'b1;
    // Power good falls on both pages, only page 0 armed so the checker sees it
    wr(1'b0, CLS_CODE_EMU, 16'h0008);
    hits0 = 4'h0;
    hits1 = 4'h0;
    power_good = 2'h0;
    repeat (5)
    begin
      @(negedge clk);
      hits0 = hits0 + 4'(scope_trigger[0]);
      hits1 = hits1 + 4'(scope_trigger[1]);
    end
    chk_bits({hits1[1:0], hits0[1:0]}, 4'h1, "scope");
    // Peak current around the fault limit, random ramping
    repeat (10)
    begin
      mant = 10'h3b0 + 10'($urandom_range(0, 15));
      output_ramping = 2'($urandom);
      phase_current_peak = {16'h0, 6'b110110, mant};
      @(negedge clk);
      chk_bits({3'h0, overcurrent_fault[0]}, {3'h0, !output_ramping[0] && mant > 10'h3b8},
               "oc fault");
    end
    // Warning unmasked, masked, then while ramping
    for (int s = 0; s < 3; s++)
    begin
      output_ramping = {1'b0, s == 2};
      alert_mask = {1'b1, s == 1};
      phase_current_avg = {16'h0, 16'hdb00};
      @(negedge clk);
      chk_bits({2'h0, status_word_iout[0], status_iout_oc_warn[0]}, s == 2 ? 4'h0 : 4'h3,
               "warn");
      chk_bits({3'h0, alert_n}, {3'h0, s != 0}, "alert");
      phase_current_avg = 32'h0;
      clear_status = 1'b1;
      @(negedge clk);
      clear_status = 1'b0;
    end
    end_sim();
  end
endmodule
